// ---- logic/sadc_pkg.sv ----
// package: register map, field layout, reset values and channel codes of the slope converter control
// Functional notes
// RL1: one of sixteen channels feeds comparator; here codes 1110/1111 close no switch, so only fourteen can
// RL2: ramp current code linear, zero is off
// RL3: hold bit stops timer, discharges capacitor
// RL4: hold bit gates off ramp current
// RL5: software holds reset at least 200 us
// RL6: mux output enable drives port A pin 0
// RL7: zero select enables zeroing inputs 1,5
// RL8: control 0 bit 3 reads zero
// RL9: both control registers read and write
// RL10: two-bit fields pick analog/digital pins
// RL11: conversion time is 2^N oscillator periods
// RL12: channel code map, 1110/1111 reserved
// RL13: 16-bit timer counts every oscillator cycle
// RL14: reset loads 02h and 00h
`default_nettype none
package sadc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0     = 8'h1f;
  localparam logic [7:0] ADDR_CTRL1     = 8'h9f;
  localparam logic [7:0] ADDR_TIMER     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] RESET_CTRL0    = 8'h02;
  localparam logic [7:0] RESET_CTRL1    = 8'h00;
  localparam logic [7:0] CTRL0_WMASK    = 8'hf7;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_ZERO_BIT   = 0;
  localparam int CTRL0_HOLD_BIT   = 1;
  localparam int CTRL0_MUXOE_BIT  = 2;
  localparam int CTRL0_CHAN_LSB   = 4;
  localparam int CTRL1_PA_LSB     = 0;
  localparam int CTRL1_PD_LSB     = 2;
  localparam int CTRL1_DAC_LSB    = 4;
  // ----------------------------------------------------------------
  // timing and analog constants
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 20000000;
  localparam int DISCHARGE_US     = 200;
  localparam int DISCHARGE_CYC    = (DISCHARGE_US * (CLK_HZ / 1000000));
  localparam int TIMER_W          = 16;
  localparam int NANOAMP_PER_CODE = 2250;
  // ----------------------------------------------------------------
  // channel codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CH_PA0 = 4'h0, CH_PA1 = 4'h1, CH_PA2 = 4'h2, CH_PA3 = 4'h3,
    CH_BANDGAP = 4'h4, CH_SREF_HIGH = 4'h5, CH_SREF_LOW = 4'h6, CH_TEMP = 4'h7,
    CH_PREF_A = 4'h8, CH_PREF_B = 4'h9, CH_PD4 = 4'ha, CH_PD5 = 4'hb,
    CH_PD6 = 4'hc, CH_PD7 = 4'hd, CH_RSVD0 = 4'he, CH_RSVD1 = 4'hf
  } sadc_chan_e;
endpackage
`default_nettype wire

// ---- logic/sadc_pincfg.sv ----
// module: decodes one two-bit port field into per-pin analog enables
`timescale 1ns/10ps
`default_nettype none
module sadc_pincfg (
  input  wire logic [1:0] cfg,
  output logic      [3:0] analog
);
  // bit k high keeps pin k analog; digital use grows from the top pin down
  always_comb begin
    case (cfg)
      2'h0:    analog = 4'hf; // RL10
      2'h1:    analog = 4'h7; // RL10
      2'h2:    analog = 4'h3; // RL10
      default: analog = 4'h0; // RL10
    endcase
  end
endmodule // sadc_pincfg
`default_nettype wire

// ---- logic/sadc_chdec.sv ----
// module: one-hot decode of the channel code onto the analog switch enables
`timescale 1ns/10ps
`default_nettype none
module sadc_chdec (
  input  wire logic [3:0]  code,
  output logic      [15:0] sel
);
  // reserved codes open every switch so nothing reaches the comparator
  always_comb begin
    sel = 16'h0000;
    if (code != sadc_pkg::CH_RSVD0 && code != sadc_pkg::CH_RSVD1) begin
      sel[code] = 1'b1; // RL1 RL12
    end
  end
endmodule // sadc_chdec
`default_nettype wire

// ---- logic/sadc_ctrl.sv ----
// module: slope converter control registers with classic wishbone slave
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl #(
  parameter int TIMER_W = sadc_pkg::TIMER_W
) (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  input  wire logic               COMP_TRIP_ASYNC,
  output logic      [15:0]        CHANNEL_SEL,
  output logic      [3:0]         CHANNEL_CODE,
  output logic      [3:0]         RAMP_CURRENT_CODE,
  output logic      [15:0]        RAMP_SOURCE_EN,
  output logic      [15:0]        RAMP_CURRENT_NA,
  output logic                    CAP_DISCHARGE,
  output logic                    MUX_TO_PA0,
  output logic                    ZERO_EN,
  output logic      [3:0]         PORTA_ANALOG,
  output logic      [3:0]         PORTD_ANALOG,
  output logic      [TIMER_W-1:0] CONVERSION_TIMER,
  output logic                    DISCHARGE_DONE
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         ctrl0;
    logic [7:0]         ctrl1;
    logic [TIMER_W-1:0] timer;
    logic [15:0]        dis_cnt;
    logic               dis_done;
    logic               ack;
    logic [31:0]        rdata;
    logic               trip_s1;
    logic               trip_s2;
    logic               trip_prev;
    logic               tripped;
    logic               ovf;
  } sadc_state_s;

  sadc_state_s r;
  sadc_state_s next_r;
  logic        hold;
  logic        req;
  logic        wr;
  logic [7:0]  wbyte;
  logic [15:0] dis_max;

  assign hold    = r.ctrl0[sadc_pkg::CTRL0_HOLD_BIT];
  assign req     = WB_CYC_I & WB_STB_I & ~r.ack;
  assign wr      = req & WB_WE_I & WB_SEL_I[0];
  assign wbyte   = WB_DAT_I[7:0];
  assign dis_max = 16'(sadc_pkg::DISCHARGE_CYC);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r         = r;
    next_r.trip_s1 = COMP_TRIP_ASYNC;
    next_r.trip_s2 = r.trip_s1;
    next_r.trip_prev = r.trip_s2;
    // one-cycle ack, dropped the cycle after so each request answers once
    next_r.ack     = req;
    next_r.rdata   = 32'h0000_0000;
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        sadc_pkg::ADDR_CTRL0:  next_r.rdata = {24'h0, r.ctrl0 & sadc_pkg::CTRL0_WMASK}; // RL8 RL9
        sadc_pkg::ADDR_CTRL1:  next_r.rdata = {24'h0, r.ctrl1}; // RL9
        sadc_pkg::ADDR_TIMER:  next_r.rdata = 32'(r.timer);
        sadc_pkg::ADDR_STATUS: next_r.rdata = {29'h0, r.ovf, r.tripped, r.dis_done};
        default:               next_r.rdata = 32'h0000_0000;
      endcase
    end
    // timer stands cleared while held; counts once per clock otherwise
    if (hold) begin
      next_r.timer = '0; // RL3
    end else begin
      next_r.timer = r.timer + 1'b1; // RL11 RL13
    end
    // discharge age is advisory: software must still respect the minimum itself
    if (hold) begin
      if (r.dis_cnt < dis_max) begin
        next_r.dis_cnt = r.dis_cnt + 16'h0001; // RL5
      end
      next_r.dis_done = (r.dis_cnt >= dis_max - 16'h0001); // RL5
    end else begin
      next_r.dis_cnt  = 16'h0000;
      next_r.dis_done = 1'b0;
    end
    // comparator falling edge marks the trip; overflow sticks until hold
    if (hold) begin
      next_r.tripped = 1'b0;
      next_r.ovf     = 1'b0;
    end else begin
      if (r.trip_prev && !r.trip_s2) begin
        next_r.tripped = 1'b1;
      end
      if (&r.timer) begin
        next_r.ovf = 1'b1;
      end
    end
    if (wr && WB_ADR_I == sadc_pkg::ADDR_CTRL0) begin
      next_r.ctrl0 = wbyte & sadc_pkg::CTRL0_WMASK; // RL8 RL9
    end
    if (wr && WB_ADR_I == sadc_pkg::ADDR_CTRL1) begin
      next_r.ctrl1 = wbyte; // RL9
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r          <= '0;
      r.ctrl0    <= sadc_pkg::RESET_CTRL0; // RL14
      r.ctrl1    <= sadc_pkg::RESET_CTRL1; // RL14
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // decoders and outputs
  // ----------------------------------------------------------------
  sadc_chdec u_chdec (
    .code (r.ctrl0[sadc_pkg::CTRL0_CHAN_LSB +: 4]),
    .sel  (CHANNEL_SEL)
  );

  sadc_pincfg u_pa (
    .cfg    (r.ctrl1[sadc_pkg::CTRL1_PA_LSB +: 2]),
    .analog (PORTA_ANALOG)
  );

  sadc_pincfg u_pd (
    .cfg    (r.ctrl1[sadc_pkg::CTRL1_PD_LSB +: 2]),
    .analog (PORTD_ANALOG)
  );

  logic [3:0] dac_code;
  assign dac_code = r.ctrl1[sadc_pkg::CTRL1_DAC_LSB +: 4];

  // thermometer of unit sources; hold masks them all
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_src
      if (g == 0) begin : g_none
        assign RAMP_SOURCE_EN[g] = 1'b0; // RL2
      end else begin : g_unit
        assign RAMP_SOURCE_EN[g] = ~hold & (dac_code >= 4'(g)); // RL2 RL4
      end
    end
  endgenerate

  assign RAMP_CURRENT_NA   = hold ? 16'h0000 :
                             16'(dac_code * sadc_pkg::NANOAMP_PER_CODE); // RL2 RL4
  assign RAMP_CURRENT_CODE = dac_code;
  assign CHANNEL_CODE      = r.ctrl0[sadc_pkg::CTRL0_CHAN_LSB +: 4]; // RL1
  assign CAP_DISCHARGE     = hold; // RL3
  assign MUX_TO_PA0        = r.ctrl0[sadc_pkg::CTRL0_MUXOE_BIT]; // RL6
  assign ZERO_EN           = r.ctrl0[sadc_pkg::CTRL0_ZERO_BIT]; // RL7
  assign CONVERSION_TIMER  = r.timer;
  assign DISCHARGE_DONE    = r.dis_done;
  assign WB_DAT_O          = r.rdata;
  assign WB_ACK_O          = r.ack;
endmodule // sadc_ctrl
`default_nettype wire

// ---- verif/sadc_ctrl_checker.sv ----
// checker: port properties of the slope converter control
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_checker #(parameter int TIMER_W = 16) (
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic               WB_STB_I,
  input wire logic               WB_WE_I,
  input wire logic [7:0]         WB_ADR_I,
  input wire logic [31:0]        WB_DAT_I,
  input wire logic [31:0]        WB_DAT_O,
  input wire logic               WB_ACK_O,
  input wire logic [15:0]        CHANNEL_SEL,
  input wire logic [3:0]         CHANNEL_CODE,
  input wire logic [3:0]         RAMP_CURRENT_CODE,
  input wire logic [15:0]        RAMP_CURRENT_NA,
  input wire logic               CAP_DISCHARGE,
  input wire logic [3:0]         PORTA_ANALOG,
  input wire logic [TIMER_W-1:0] CONVERSION_TIMER
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic wr0, wr1;
  assign wr0 = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h1f;
  assign wr1 = WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h9f;
  chk_ack_pulse: assert property (
    $rose(WB_STB_I) |=> WB_ACK_O ##1 !WB_ACK_O) else $error("ack not one pulse");
  chk_chan_decode: assert property (
    CHANNEL_SEL == (CHANNEL_CODE > 4'hd ? 16'h0 : 16'h1 << CHANNEL_CODE)) else $error("chan");
  chk_current_lin: assert property (
    RAMP_CURRENT_NA == (CAP_DISCHARGE ? 16'h0 : RAMP_CURRENT_CODE * 16'd2250)) else $error("nA");
  chk_timer_hold: assert property (
    CAP_DISCHARGE && $past(CAP_DISCHARGE) |-> CONVERSION_TIMER == '0) else $error("timer held");
  chk_timer_step: assert property (
    !CAP_DISCHARGE && !$past(CAP_DISCHARGE) |-> CONVERSION_TIMER == $past(CONVERSION_TIMER) + 1'b1)
    else $error("timer step");
  chk_ctrl0_write: assert property (
    wr0 |-> CHANNEL_CODE == WB_DAT_I[7:4] && CAP_DISCHARGE == WB_DAT_I[1]) else $error("ctrl0");
  chk_port_cfg: assert property (
    wr1 |-> RAMP_CURRENT_CODE == WB_DAT_I[7:4]
      && PORTA_ANALOG == (WB_DAT_I[1:0] == 2'h3 ? 4'h0 : 4'hf >> WB_DAT_I[1:0])) else $error("cfg");
  chk_read_zero: assert property (
    WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h1f |-> WB_DAT_O[31:3] == {24'h0, CHANNEL_CODE, 1'b0})
    else $error("ctrl0 read");
endmodule // sadc_ctrl_checker
bind sadc_ctrl sadc_ctrl_checker #(.TIMER_W(TIMER_W)) i_sadc_ctrl_checker (.*);
`default_nettype wire

// ---- verif/sadc_ramp_model.sv ----
// partner model: ramp capacitor, current source and comparator
`timescale 1ns/10ps
`default_nettype none
module sadc_ramp_model (
  input  wire logic [15:0] CHANNEL_SEL,
  input  wire logic [15:0] RAMP_CURRENT_NA,
  input  wire logic        CAP_DISCHARGE,
  input  wire logic        CLK,
  output logic             COMP_OUT
);
  // input level is a stand-in scaled from the one-hot code, not a voltage
  logic [31:0] ramp = 32'h0;
  always @(posedge CLK) ramp <= CAP_DISCHARGE ? 32'h0 : ramp + RAMP_CURRENT_NA;
  assign COMP_OUT = ramp <= {8'h0, CHANNEL_SEL, 8'h0};
endmodule // sadc_ramp_model
`default_nettype wire

// ---- verif/sadc_ctrl_test.sv ----
// testbench: bus traffic and output checks of the slope converter control
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module sadc_ctrl_test;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, hold, trip;
  logic        dead = 1'b0, mux, zen, done;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0, pa, pd;
  logic [15:0] chsel, na, src, tmr;
  logic [31:0] dat = 32'h0, rd, dato, lf = 32'h169a6e82;
  int          num_errors = 0, num_checks = 0;
  sadc_ctrl i_sadc_ctrl (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .COMP_TRIP_ASYNC(trip), .CHANNEL_SEL(chsel), .CHANNEL_CODE(), .RAMP_CURRENT_CODE(),
    .RAMP_SOURCE_EN(src), .RAMP_CURRENT_NA(na), .CAP_DISCHARGE(hold), .MUX_TO_PA0(mux),
    .ZERO_EN(zen), .PORTA_ANALOG(pa), .PORTD_ANALOG(pd), .CONVERSION_TIMER(tmr),
    .DISCHARGE_DONE(done));
  sadc_ramp_model i_sadc_ramp_model (.CLK(clk), .CHANNEL_SEL(chsel), .RAMP_CURRENT_NA(na),
    .CAP_DISCHARGE(hold), .COMP_OUT(trip));
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // analog pins per port field: digital use takes pins from the top down
  function automatic logic [3:0] cfg_exp(input logic [1:0] c);
    return (c == 2'h3) ? 4'h0 : (4'hf >> c);
  endfunction
  // unit sources 1..code on, source 0 never used
  function automatic logic [15:0] therm(input logic [3:0] c);
    return 16'((32'h1 << (32'(c) + 1)) - 32'h2);
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ack is sampled at the rising edge; a lost answer stops all further traffic
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    if (dead) return;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'h1, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      num_errors++;
      dead = 1'b1;
    end
    rd = dato;
    {cyc, stb} <= 2'b00;
  endtask
  initial forever #25 clk = ~clk;
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h1f, 32'h0);
    `CHK("ctrl0", 32'h2, rd)
    `CHK("timer pin", 16'h0, tmr)
    repeat (4000) @(posedge clk);
    wb(1'b0, 8'h10, 32'h0);
    `CHK("done", 32'h1, rd)
    `CHK("done pin", 1'b1, done)
    $display("reset test over");
    for (int i = 0; i < 16; i++) begin
      lf = step(lf);
      wb(1'b1, 8'h1f, {24'h0, i[3:0], lf[3:0]});
      wb(1'b1, 8'h9f, {24'h0, i[3:0], lf[7:4]});
      wb(1'b0, 8'h1f, 32'h0);
      `CHK("ctrl0", {24'h0, i[3:0], 1'b0, lf[2:0]}, rd)
      `CHK("chan", i > 13 ? 16'h0 : 16'h1 << i, chsel)
      `CHK("nA", lf[1] ? 16'h0 : 16'(i * 2250), na)
      `CHK("sources", lf[1] ? 16'h0 : therm(i[3:0]), src)
      `CHK("mux pin", lf[2], mux)
      `CHK("zeroing", lf[0], zen)
      `CHK("porta", cfg_exp(lf[5:4]), pa)
      `CHK("portd", cfg_exp(lf[7:6]), pd)
    end
    wb(1'b0, 8'h55, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("register test over");
    // discharge first so the release gives a fresh comparator fall
    wb(1'b1, 8'h1f, 32'h42);
    repeat (10) @(posedge clk);
    wb(1'b1, 8'h1f, 32'h40);
    wb(1'b0, 8'h0c, 32'h0);
    lf = rd + 32'h3;
    wb(1'b0, 8'h0c, 32'h0);
    `CHK("timer", lf, rd)
    wb(1'b0, 8'h10, 32'h0);
    `CHK("trip", 32'h2, rd)
    $display("conversion test over");
    print_verdict;
  end
endmodule // sadc_ctrl_test
`default_nettype wire
